// ### rtl/mtlb_lookup.sv
// main translation buffer: arbitration, match, checks, walk and refill
//
// Summary of operation
// - misses of both micro buffers are served by this one shared buffer.
// - latency varies with arbitration, answers come by a valid flag, not a fixed count.
// - storage is 128 entries as two ways of 64 sets.
// - each entry holds address, size, physical address, properties, tag or global mark.
// - the current tag for lookups comes from the context identifier register.
// - a hit needs equal address, equal security world, and equal tag or global.
// - entries map 16 Mbyte, 1 Mbyte, 64 Kbyte or 4 Kbyte blocks each as one entry.
// - micro lookup first, then this buffer, and a walk only on a miss here.
// - on a miss with walks enabled the table is walked and a result without fault installed.
// - write-back inner cacheability sends walk reads to the data cache, else outside.
// - a miss with walks disabled for its base gives a section translation fault.
// - a hit is checked for permission and domain, and a failure aborts.
// - region attributes come from the entry combined with the remap register.
// - a hit that passes gives the physical address built from the entry.
`timescale 1ns/1ns
`default_nettype none
`include "mtlb_params.svh"
module mtlb_lookup (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire mtlb_pkg::mtlb_req_t ireq_i,
  input wire mtlb_pkg::mtlb_req_t dreq_i,
  output logic iready_o,
  output logic dready_o,
  output mtlb_pkg::mtlb_resp_t resp_o,
  output mtlb_pkg::mtlb_walk_req_t walk_o,
  input wire logic walk_done_i,
  input wire logic walk_fault_i,
  input wire mtlb_pkg::mtlb_entry_t walk_entry_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o
);
  import mtlb_pkg::*;

  typedef enum logic [2:0] {
    MTLB_IDLE,
    MTLB_READ,
    MTLB_CMP,
    MTLB_WALK,
    MTLB_FILL
  } mtlb_state_t;

  // base mask of virtual page number bits per block size
  function automatic logic [19:0] size_mask(input mtlb_size_t sz);
    unique case (sz)
      MTLB_SZ_SMALL: size_mask = 20'hF_FFFF;
      MTLB_SZ_LARGE: size_mask = 20'hF_FFF0;
      MTLB_SZ_SECTION: size_mask = 20'hF_FF00;
      MTLB_SZ_SUPER: size_mask = 20'hF_F000;
    endcase
  endfunction

  function automatic logic entry_hit(input mtlb_entry_t e, input mtlb_req_t r,
                                     input logic [7:0] tag);
    logic [19:0] m;
    m = size_mask(e.size);
    entry_hit = e.valid && ((e.vpn & m) == (r.vaddr[31:12] & m))
      && (e.security_world_tag == r.nonsecure)
      && (e.global_flag || (e.app_space_tag == tag));
  endfunction

  mtlb_state_t state_reg;
  mtlb_req_t cur_reg;
  logic last_d_reg;
  logic [31:0] ctrl_reg, ctx_reg, dacr_reg, remap_reg;
  logic [2:0] status_reg, irq_en_reg;
  logic [3:0] fault_reg;
  logic [63:0] rr_reg;
  mtlb_entry_t rd0, rd1, hit_e, fill_e;
  mtlb_entry_t fill_reg;
  logic [5:0] idx;
  logic hit0, hit1, fill_wr, fill_way;
  logic ev_fault, ev_walk, ev_install;
  logic [1:0] dom_bits;
  logic perm_ok, walk_off;
  logic [19:0] pmask;

  assign idx = cur_reg.vaddr[17:12];
  // walker entry only stands beside its done pulse, so keep it for the install cycle
  always_ff @(posedge sys_clk_i) begin
    if (state_reg == MTLB_WALK && walk_done_i) begin
      fill_reg <= walk_entry_i;
    end
  end
  assign fill_e = fill_reg;
  assign fill_wr = (state_reg == MTLB_FILL);
  assign fill_way = rd0.valid ? (rd1.valid ? rr_reg[idx] : 1'b1) : 1'b0;

  // two ways of 64 sets make the 128 entries
  mtlb_way_ram u_way0 (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .rd_idx_i(idx),
    .wr_en_i(fill_wr && !fill_way),
    .wr_idx_i(idx),
    .wr_data_i(fill_e),
    .rd_data_o(rd0)
  );
  mtlb_way_ram u_way1 (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .rd_idx_i(idx),
    .wr_en_i(fill_wr && fill_way),
    .wr_idx_i(idx),
    .wr_data_i(fill_e),
    .rd_data_o(rd1)
  );

  // lookup against the current tag from the context register
  assign hit0 = entry_hit(rd0, cur_reg, ctx_reg[7:0]);
  assign hit1 = entry_hit(rd1, cur_reg, ctx_reg[7:0]);
  assign hit_e = hit1 ? rd1 : rd0; // single match assumed
  assign walk_off = cur_reg.vaddr[31] ? ctrl_reg[`MTLB_CTRL_PD1]
                                      : ctrl_reg[`MTLB_CTRL_PD0];

  // domain: 00 no access, 01 client checks ap, 11 manager skips checks
  assign dom_bits = dacr_reg[{hit_e.domain, 1'b0} +: 2];
  always_comb begin
    perm_ok = 1'b0;
    unique case (hit_e.ap[1:0])
      2'b00: perm_ok = 1'b0;
      2'b01: perm_ok = cur_reg.privileged;
      2'b10: perm_ok = cur_reg.privileged || !cur_reg.write;
      2'b11: perm_ok = !(hit_e.ap[2] && cur_reg.write);
    endcase
    if (hit_e.ap[2] && cur_reg.write) begin
      perm_ok = 1'b0;
    end
  end
  assign pmask = size_mask(hit_e.size);

  // sequencer: the choice of requester alternates when both wait
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_reg <= MTLB_IDLE;
      cur_reg <= '0;
      last_d_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        MTLB_IDLE: begin
          if (ireq_i.valid && (!dreq_i.valid || last_d_reg)) begin
            cur_reg <= ireq_i;
            cur_reg.instr <= 1'b1;
            last_d_reg <= 1'b0;
            state_reg <= MTLB_READ;
          end else if (dreq_i.valid) begin
            cur_reg <= dreq_i;
            cur_reg.instr <= 1'b0;
            last_d_reg <= 1'b1;
            state_reg <= MTLB_READ;
          end
        end
        MTLB_READ: state_reg <= MTLB_CMP;
        MTLB_CMP: begin
          if (hit0 || hit1 || walk_off) begin
            state_reg <= MTLB_IDLE;
          end else begin
            state_reg <= MTLB_WALK;
          end
        end
        MTLB_WALK: begin
          if (walk_done_i) begin
            state_reg <= walk_fault_i ? MTLB_IDLE : MTLB_FILL;
          end
        end
        MTLB_FILL: state_reg <= MTLB_READ; // replay lookup after install
        default: state_reg <= MTLB_IDLE;
      endcase
    end
  end

  // acceptance strobes back to the micro buffers
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      iready_o <= 1'b0;
      dready_o <= 1'b0;
    end else begin
      iready_o <= (state_reg == MTLB_IDLE) && ireq_i.valid && (!dreq_i.valid || last_d_reg);
      dready_o <= (state_reg == MTLB_IDLE) && dreq_i.valid && !(ireq_i.valid
                   && (!dreq_i.valid || last_d_reg));
    end
  end

  // answer: translation on a passing hit, abort otherwise
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      resp_o <= '0;
    end else begin
      resp_o.valid <= 1'b0;
      if (state_reg == MTLB_CMP && (hit0 || hit1)) begin
        resp_o.valid <= 1'b1;
        resp_o.instr <= cur_reg.instr;
        resp_o.abort <= (dom_bits == 2'b11) ? 1'b0 : !(dom_bits == 2'b01 && perm_ok);
        resp_o.fault_status <= (dom_bits == 2'b11) ? `MTLB_FS_NONE
          : (dom_bits != 2'b01) ? `MTLB_FS_DOMAIN
          : perm_ok ? `MTLB_FS_NONE : `MTLB_FS_PERM;
        resp_o.paddr <= {(hit_e.ppn & pmask) | (cur_reg.vaddr[31:12] & ~pmask),
                         cur_reg.vaddr[11:0]};
        resp_o.nonsecure <= hit_e.security_world_tag | cur_reg.nonsecure;
        resp_o.shareable <= remap_reg[{hit_e.attr, 2'b00} + 5'd2];
        resp_o.mem_type <= remap_reg[{hit_e.attr, 2'b00} +: 2];
      end else if ((state_reg == MTLB_CMP && walk_off)
                   || (state_reg == MTLB_WALK && walk_done_i && walk_fault_i)) begin
        resp_o.valid <= 1'b1;
        resp_o.instr <= cur_reg.instr;
        resp_o.abort <= 1'b1;
        resp_o.fault_status <= `MTLB_FS_SECTION;
        resp_o.paddr <= 32'h0000_0000;
      end
    end
  end

  // walk request held until the walker answers
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      walk_o <= '0;
    end else if (state_reg == MTLB_CMP && !hit0 && !hit1 && !walk_off) begin
      walk_o.req <= 1'b1;
      walk_o.vaddr <= cur_reg.vaddr;
      walk_o.nonsecure <= cur_reg.nonsecure;
      walk_o.base_one <= cur_reg.vaddr[31];
      walk_o.via_dcache <= ctrl_reg[`MTLB_CTRL_WALK_INNER_CACHEABILITY_LO + `MTLB_WALK_INNER_CACHEABILITY_WB_BIT];
    end else if (walk_done_i) begin
      walk_o.req <= 1'b0;
    end
  end

  // per-set round-robin victim pointer
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rr_reg <= 64'h0000_0000_0000_0000;
    end else if (fill_wr && rd0.valid && rd1.valid) begin
      rr_reg[idx] <= ~rr_reg[idx];
    end
  end

  // software registers
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ctrl_reg <= `MTLB_CTRL_RESET;
      ctx_reg <= 32'h0000_0000;
      dacr_reg <= `MTLB_DACR_RESET;
      remap_reg <= `MTLB_REMAP_RESET;
      irq_en_reg <= 3'h0;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `MTLB_OFF_CTRL: ctrl_reg <= {28'h000_0000, reg_wdata_i[3:0]};
        `MTLB_OFF_CTXID: ctx_reg <= reg_wdata_i;
        `MTLB_OFF_IRQ_EN: irq_en_reg <= reg_wdata_i[2:0];
        `MTLB_OFF_DACR: dacr_reg <= reg_wdata_i;
        `MTLB_OFF_REMAP: remap_reg <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // sticky events, a new event wins over a clear in the same cycle
  assign ev_fault = resp_o.valid && resp_o.abort;
  assign ev_walk = (state_reg == MTLB_CMP) && !hit0 && !hit1 && !walk_off;
  assign ev_install = fill_wr;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      status_reg <= 3'h0;
      fault_reg <= `MTLB_FS_NONE;
    end else begin
      status_reg <= (status_reg & ~((reg_wr_i && reg_addr_i == `MTLB_OFF_IRQ_CLR)
                     ? reg_wdata_i[2:0] : 3'h0)) | {ev_install, ev_walk, ev_fault};
      if (ev_fault) begin
        fault_reg <= resp_o.fault_status;
      end
    end
  end

  // read port, data in the next cycle
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 32'h0000_0000;
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_reg & irq_en_reg);
      reg_rdata_o <= 32'h0000_0000;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          `MTLB_OFF_CTRL: reg_rdata_o <= ctrl_reg;
          `MTLB_OFF_CTXID: reg_rdata_o <= ctx_reg;
          `MTLB_OFF_STATUS: reg_rdata_o <= {29'h0000_0000, status_reg};
          `MTLB_OFF_IRQ_EN: reg_rdata_o <= {29'h0000_0000, irq_en_reg};
          `MTLB_OFF_FAULT: reg_rdata_o <= {28'h000_0000, fault_reg};
          `MTLB_OFF_DACR: reg_rdata_o <= dacr_reg;
          `MTLB_OFF_REMAP: reg_rdata_o <= remap_reg;
          default: reg_rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  a_walk_off_fault: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (state_reg == MTLB_CMP && !hit0 && !hit1 && walk_off) |=>
      (resp_o.valid && resp_o.abort && resp_o.fault_status == `MTLB_FS_SECTION))
    else $error("disabled walk did not fault");
  a_miss_walks: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (state_reg == MTLB_CMP && !hit0 && !hit1 && !walk_off) |=> walk_o.req && !resp_o.valid)
    else $error("miss did not start walk");
  a_hit_no_walk: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (state_reg == MTLB_CMP && (hit0 || hit1)) |=> resp_o.valid && $stable(walk_o.req))
    else $error("hit did not answer");
  a_walk_route: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $rose(walk_o.req) |-> walk_o.via_dcache == $past(ctrl_reg[`MTLB_CTRL_WALK_INNER_CACHEABILITY_LO]))
    else $error("walk routed wrongly");
  a_fill_replays: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (state_reg == MTLB_FILL) |=> (state_reg == MTLB_READ) ##1 (state_reg == MTLB_CMP))
    else $error("install not replayed");
  a_fair_grant: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (state_reg == MTLB_IDLE && ireq_i.valid && dreq_i.valid && !last_d_reg) |=> dready_o)
    else $error("arbitration did not alternate");
  a_one_grant: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !(iready_o && dready_o))
    else $error("both requesters granted");
  a_victim_turn: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (fill_wr && rd0.valid && rd1.valid) |=> rr_reg[$past(idx)] != $past(rr_reg[idx]))
    else $error("victim pointer stuck");
  a_irq_level: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    |(status_reg & irq_en_reg) |=> irq_o)
    else $error("interrupt not raised");
endmodule // mtlb_lookup
`default_nettype wire

// ### rtl/mtlb_params.svh
// constants for the main translation buffer: offsets, fields, reset values, widths
`ifndef MTLB_PARAMS_SVH
`define MTLB_PARAMS_SVH
`define MTLB_SETS 64
`define MTLB_IDX_W 6
`define MTLB_TAG_W 8
`define MTLB_VPN_W 20
// register offsets on the plain port (byte addresses)
`define MTLB_OFF_CTRL 8'h00
`define MTLB_OFF_CTXID 8'h04
`define MTLB_OFF_STATUS 8'h08
`define MTLB_OFF_IRQ_CLR 8'h0C
`define MTLB_OFF_IRQ_EN 8'h10
`define MTLB_OFF_FAULT 8'h14
`define MTLB_OFF_DACR 8'h18
`define MTLB_OFF_REMAP 8'h1C
// control register fields
`define MTLB_CTRL_PD0 0
`define MTLB_CTRL_PD1 1
`define MTLB_CTRL_WALK_INNER_CACHEABILITY_LO 2
`define MTLB_CTRL_RESET 32'h0000_0000
`define MTLB_REMAP_RESET 32'h0000_0000
`define MTLB_DACR_RESET 32'h0000_0000
// inner cacheability encodings: 01 and 11 are write-back
`define MTLB_WALK_INNER_CACHEABILITY_WB_BIT 0
// fault status codes
`define MTLB_FS_NONE 4'h0
`define MTLB_FS_SECTION 4'h5
`define MTLB_FS_DOMAIN 4'h9
`define MTLB_FS_PERM 4'hD
// status / interrupt bits
`define MTLB_ST_FAULT 0
`define MTLB_ST_WALK 1
`define MTLB_ST_INSTALL 2
`endif

// ### rtl/mtlb_pkg.sv
// types shared by the main translation buffer design
`timescale 1ns/1ns
`default_nettype none
package mtlb_pkg;
  typedef enum logic [1:0] {
    MTLB_SZ_SMALL,
    MTLB_SZ_LARGE,
    MTLB_SZ_SECTION,
    MTLB_SZ_SUPER
  } mtlb_size_t;

  typedef struct packed {
    logic valid;
    logic [19:0] vpn;
    mtlb_size_t size;
    logic [19:0] ppn;
    logic [7:0] app_space_tag;
    logic global_flag;
    logic security_world_tag;
    logic [3:0] domain;
    logic [2:0] ap;
    logic [2:0] attr;
  } mtlb_entry_t;

  typedef struct packed {
    logic valid;
    logic instr;
    logic [31:0] vaddr;
    logic nonsecure;
    logic privileged;
    logic write;
  } mtlb_req_t;

  typedef struct packed {
    logic valid;
    logic instr;
    logic abort;
    logic [3:0] fault_status;
    logic [31:0] paddr;
    logic nonsecure;
    logic shareable;
    logic [1:0] mem_type;
  } mtlb_resp_t;

  typedef struct packed {
    logic req;
    logic [31:0] vaddr;
    logic via_dcache;
    logic nonsecure;
    logic base_one;
  } mtlb_walk_req_t;
endpackage : mtlb_pkg
`default_nettype wire

// ### rtl/mtlb_way_ram.sv
// one way of entry storage, registered read port
`timescale 1ns/1ns
`default_nettype none
module mtlb_way_ram (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [5:0] rd_idx_i,
  input wire logic wr_en_i,
  input wire logic [5:0] wr_idx_i,
  input wire mtlb_pkg::mtlb_entry_t wr_data_i,
  output mtlb_pkg::mtlb_entry_t rd_data_o
);
  import mtlb_pkg::*;
  mtlb_entry_t mem_reg [0:63];
  logic [63:0] valid_reg;

  // valid bits reset, payload does not need to
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      valid_reg <= 64'h0000_0000_0000_0000;
    end else if (wr_en_i) begin
      valid_reg[wr_idx_i] <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      mem_reg[wr_idx_i] <= wr_data_i;
    end
  end

  // read data registered; valid folded in from reset-cleared bits
  always_ff @(posedge sys_clk_i) begin
    rd_data_o <= mem_reg[rd_idx_i];
    rd_data_o.valid <= valid_reg[rd_idx_i] & ~reset_i;
  end
endmodule // mtlb_way_ram
`default_nettype wire

// ### tb/mtlb_walk_model.sv
// table walker model: answers walk requests from a fixed mapping
`timescale 1ns/1ns
`default_nettype none
module mtlb_walk_model (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire mtlb_pkg::mtlb_walk_req_t walk_i,
  input wire logic [7:0] tag_i,
  input wire logic glob_i,
  input wire logic [2:0] ap_i,
  input wire logic [3:0] dom_i,
  input wire logic [2:0] attr_i,
  input wire logic fault_i,
  input wire mtlb_pkg::mtlb_size_t size_i,
  output logic done_o,
  output logic fault_o,
  output mtlb_pkg::mtlb_entry_t entry_o,
  output logic [7:0] count_o,
  output logic via_dcache_o,
  output logic base_one_o
);
  import mtlb_pkg::*;
  logic busy_reg;
  logic [3:0] wait_reg;
  // one walk at a time; every second walk stalls six cycles so slow answers are seen too
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      busy_reg <= 1'b0;
      wait_reg <= 4'h0;
      done_o <= 1'b0;
      fault_o <= 1'b0;
      entry_o <= '0;
      count_o <= 8'h00;
      via_dcache_o <= 1'b0;
      base_one_o <= 1'b0;
    end else if (done_o) begin
      done_o <= 1'b0;
      fault_o <= 1'b0;
      entry_o <= mtlb_entry_t'(~entry_o); // released bus must not keep a stale entry
    end else if (busy_reg) begin
      if (wait_reg == 4'h0) begin
        busy_reg <= 1'b0;
        done_o <= 1'b1;
        fault_o <= fault_i;
        // one mapping per walked block; tests keep blocks apart so none overlap
        entry_o <= '{valid: 1'b1, vpn: walk_i.vaddr[31:12], size: size_i,
                     ppn: walk_i.vaddr[31:12] ^ 20'hf_0000, app_space_tag: tag_i,
                     global_flag: glob_i, security_world_tag: walk_i.nonsecure,
                     domain: dom_i, ap: ap_i, attr: attr_i};
      end else begin
        wait_reg <= wait_reg - 4'h1;
      end
    end else if (walk_i.req) begin
      busy_reg <= 1'b1;
      wait_reg <= count_o[0] ? 4'h6 : 4'h0;
      count_o <= count_o + 8'h01;
      via_dcache_o <= walk_i.via_dcache;
      base_one_o <= walk_i.base_one;
    end
  end
endmodule // mtlb_walk_model
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the main translation buffer lookup
`timescale 1ns/1ns
`default_nettype none
`include "mtlb_params.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
  import mtlb_pkg::*;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  mtlb_req_t ireq_i = '0;
  mtlb_req_t dreq_i = '0;
  logic iready_o, dready_o, irq_o, walk_done_i, walk_fault_i, via_dc, base_one;
  mtlb_resp_t resp_o, r;
  mtlb_walk_req_t walk_o;
  mtlb_entry_t walk_entry_i;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [7:0] tag = 8'h21;
  logic [7:0] walks;
  logic glob = 1'b0;
  logic [2:0] ap = 3'h3;
  logic [3:0] dom = 4'h0;
  logic wfault = 1'b0;
  mtlb_size_t sz = MTLB_SZ_SMALL;
  int n_errors = 0;
  int comparisons = 0;
  time t_i, t_d;
  always #4 sys_clk_i = ~sys_clk_i;
  mtlb_lookup dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .ireq_i(ireq_i),
    .dreq_i(dreq_i), .iready_o(iready_o), .dready_o(dready_o), .resp_o(resp_o),
    .walk_o(walk_o), .walk_done_i(walk_done_i), .walk_fault_i(walk_fault_i),
    .walk_entry_i(walk_entry_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
  mtlb_walk_model walker_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .walk_i(walk_o),
    .tag_i(tag), .glob_i(glob), .ap_i(ap), .dom_i(dom), .attr_i(3'h1), .fault_i(wfault),
    .size_i(sz), .done_o(walk_done_i), .fault_o(walk_fault_i), .entry_o(walk_entry_i),
    .count_o(walks), .via_dcache_o(via_dc), .base_one_o(base_one));
  // verdict and end of run
  task automatic results();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge sys_clk_i);
    `CHK(reg_rdata_o, e);
  endtask
  // one translation: hold valid until ready, then await the answer for this side
  task automatic tr(input logic side, input logic [31:0] va, input logic ns,
                    input logic wr_b, input logic [7:0] nw, input logic [3:0] fs);
    mtlb_req_t q;
    mtlb_resp_t a;
    logic [7:0] w0;
    int k;
    q = '{valid: 1'b1, instr: side, vaddr: va, nonsecure: ns, privileged: 1'b1, write: wr_b};
    w0 = walks;
    @(posedge sys_clk_i);
    if (side)
      ireq_i <= q;
    else
      dreq_i <= q;
    for (k = 0; k < 60 && (side ? iready_o : dready_o) !== 1'b1; k++)
      @(posedge sys_clk_i);
    if (side)
      ireq_i.valid <= 1'b0;
    else
      dreq_i.valid <= 1'b0;
    for (k = 0; k < 100 && !(resp_o.valid === 1'b1 && resp_o.instr === side); k++)
      @(posedge sys_clk_i);
    a = resp_o;
    r = a;
    `CHK(a.valid, 1'b1);
    `CHK(walks - w0, nw);
    `CHK(a.abort, fs != `MTLB_FS_NONE);
    `CHK(a.fault_status, fs);
    if (fs == `MTLB_FS_NONE)
      `CHK(a.paddr, {va[31:12] ^ 20'hf_0000, va[11:0]});
  endtask
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #(8 * 20000);
    n_errors++;
    results();
  end
  initial begin
    repeat (8) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd(`MTLB_OFF_CTRL, `MTLB_CTRL_RESET);
    rd(`MTLB_OFF_REMAP, `MTLB_REMAP_RESET);
    rd(`MTLB_OFF_DACR, `MTLB_DACR_RESET);
    rd(`MTLB_OFF_STATUS, 32'h0000_0000);
    wr(8'hfc, 32'hffff_ffff);
    rd(8'hfc, 32'h0000_0000);
    // domain 0 client, domain 1 no access; attribute 1 remaps to shareable type 2
    wr(`MTLB_OFF_DACR, 32'h0000_0001);
    wr(`MTLB_OFF_REMAP, 32'h0000_0060);
    wr(`MTLB_OFF_CTXID, 32'h0000_0021);
    wr(`MTLB_OFF_IRQ_EN, 32'h0000_0001);
    wr(`MTLB_OFF_CTRL, 32'h0000_0001);
    tr(1'b1, 32'h0000_1000, 1'b0, 1'b0, 8'h00, `MTLB_FS_SECTION);
    rd(`MTLB_OFF_FAULT, 32'h0000_0005);
    rd(`MTLB_OFF_STATUS, 32'h0000_0001);
    `CHK(irq_o, 1'b1);
    wr(`MTLB_OFF_IRQ_CLR, 32'h0000_0007);
    rd(`MTLB_OFF_STATUS, 32'h0000_0000);
    `CHK(irq_o, 1'b0);
    tr(1'b0, 32'h8000_2000, 1'b0, 1'b0, 8'h01, `MTLB_FS_NONE);
    `CHK(base_one, 1'b1);
    `CHK(via_dc, 1'b0);
    wr(`MTLB_OFF_CTRL, 32'h0000_0006);
    tr(1'b1, 32'h8000_5000, 1'b0, 1'b0, 8'h00, `MTLB_FS_SECTION);
    tr(1'b0, 32'h0001_2345, 1'b0, 1'b0, 8'h01, `MTLB_FS_NONE);
    `CHK(via_dc, 1'b1);
    `CHK(r.mem_type, 2'h2);
    `CHK(r.shareable, 1'b1);
    tr(1'b1, 32'h0001_2345, 1'b0, 1'b0, 8'h00, `MTLB_FS_NONE);
    tr(1'b0, 32'h0001_2345, 1'b1, 1'b0, 8'h01, `MTLB_FS_NONE);
    `CHK(r.nonsecure, 1'b1);
    ap = 3'h7;
    tr(1'b0, 32'h0003_0000, 1'b0, 1'b1, 8'h01, `MTLB_FS_PERM);
    tr(1'b0, 32'h0003_0000, 1'b0, 1'b0, 8'h00, `MTLB_FS_NONE);
    ap = 3'h3;
    dom = 4'h1;
    tr(1'b0, 32'h0004_0000, 1'b0, 1'b0, 8'h01, `MTLB_FS_DOMAIN);
    dom = 4'h0;
    tag = 8'h22;
    wr(`MTLB_OFF_CTXID, 32'h0000_0022);
    tr(1'b0, 32'h0001_2345, 1'b0, 1'b0, 8'h01, `MTLB_FS_NONE);
    glob = 1'b1;
    tr(1'b1, 32'h0005_0000, 1'b0, 1'b0, 8'h01, `MTLB_FS_NONE);
    glob = 1'b0;
    tag = 8'h33;
    wr(`MTLB_OFF_CTXID, 32'h0000_0033);
    tr(1'b1, 32'h0005_0000, 1'b0, 1'b0, 8'h00, `MTLB_FS_NONE);
    tr(1'b0, 32'h0001_2345, 1'b0, 1'b0, 8'h01, `MTLB_FS_NONE);
    wfault = 1'b1;
    tr(1'b0, 32'h0006_0000, 1'b0, 1'b0, 8'h01, `MTLB_FS_SECTION);
    wfault = 1'b0;
    // three pages in set 7: both ways hold two, a third replaces one of them
    tr(1'b0, 32'h0010_7000, 1'b0, 1'b0, 8'h01, `MTLB_FS_NONE);
    tr(1'b0, 32'h0020_7000, 1'b0, 1'b0, 8'h01, `MTLB_FS_NONE);
    tr(1'b1, 32'h0010_7000, 1'b0, 1'b0, 8'h00, `MTLB_FS_NONE);
    tr(1'b0, 32'h0030_7000, 1'b0, 1'b0, 8'h01, `MTLB_FS_NONE);
    tr(1'b1, 32'h0030_7000, 1'b0, 1'b0, 8'h00, `MTLB_FS_NONE);
    tr(1'b1, 32'h0010_7000, 1'b0, 1'b0, 8'h01, `MTLB_FS_NONE);
    // a section entry walked in set 0 covers another page of its block
    sz = MTLB_SZ_SECTION;
    tr(1'b0, 32'h0040_0000, 1'b0, 1'b0, 8'h01, `MTLB_FS_NONE);
    sz = MTLB_SZ_SMALL;
    tr(1'b1, 32'h004C_0123, 1'b0, 1'b0, 8'h00, `MTLB_FS_NONE);
    // both sides at once: fetch was granted last, so the data side goes first
    fork
      begin
        tr(1'b1, 32'h0005_0000, 1'b0, 1'b0, 8'h00, `MTLB_FS_NONE);
        t_i = $time;
      end
      begin
        tr(1'b0, 32'h0001_2345, 1'b0, 1'b0, 8'h00, `MTLB_FS_NONE);
        t_d = $time;
      end
    join
    `CHK(t_d < t_i, 1'b1);
    rd(`MTLB_OFF_STATUS, 32'h0000_0007);
    results();
  end
endmodule // tb
`default_nettype wire
